// [src/fuse_prog_pkg.sv]
// Constants and types shared by the fuse trim programmer
package fuse_prog_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int TICK_NS           = 1000;
  localparam int TICK_CYCLES       = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_US          = 20;
  localparam int GAP_US            = 20;
  localparam int POWER_UP_US       = 100;
  localparam int BLOW_DURATION_US  = 200;
  localparam int POST_BLOW_DELAY_US = 100;
  localparam int POWER_OFF_US      = 1000;
  localparam int CHECK_SETTLE_US   = 50;
  localparam int TIMER_W           = 16;

  // ----------------------------------------------------------------
  // Device programming keys and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] KEY_TRIM_UP     = 4'h0;
  localparam logic [3:0] KEY_LOCK_CHECK  = 4'h7;
  localparam logic [6:0] BLOW_MODE_KEY   = 7'h09;
  localparam logic [6:0] CHECK_CODE_LOW  = 7'h07;
  localparam logic [6:0] CHECK_CODE_HIGH = 7'h0F;
  localparam logic [5:0] LOCK_BIT_MASK   = 6'h08;
  localparam int         FIELD_W         = 6;

  // ----------------------------------------------------------------
  // Supply pin levels
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_NOM  = 2'h1;
  localparam logic [1:0] LVL_MID  = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_KEY    = 12'h004;
  localparam logic [11:0] ADDR_CODE   = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_ARM_BIT   = 4;
  localparam int CTRL_HIGH_BIT  = 5;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_ERROR_BIT   = 2;
  localparam int ST_MARGIN_BIT  = 3;
  localparam int ST_LOCKED_BIT  = 4;
  localparam int ST_HOLD_BIT    = 5;
  localparam int ST_BLOWN_LSB   = 8;

  // ----------------------------------------------------------------
  // Commands, stages and states
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_TRY   = 3'h0;
  localparam logic [2:0] OP_BLOW  = 3'h1;
  localparam logic [2:0] OP_LOCK  = 3'h2;
  localparam logic [2:0] OP_CHECK = 3'h3;
  localparam logic [2:0] OP_OFF   = 3'h4;

  localparam logic [2:0] STG_KEY_MID   = 3'h0;
  localparam logic [2:0] STG_KEY_HIGH  = 3'h1;
  localparam logic [2:0] STG_MODE_MID  = 3'h2;
  localparam logic [2:0] STG_MODE_HIGH = 3'h3;
  localparam logic [2:0] STG_ADDR      = 3'h4;

  typedef enum logic [7:0] {
    S_IDLE     = 8'b0000_0001,
    S_POWER_UP = 8'b0000_0010,
    S_PULSE    = 8'b0000_0100,
    S_GAP      = 8'b0000_1000,
    S_BLOW     = 8'b0001_0000,
    S_POST     = 8'b0010_0000,
    S_OFF      = 8'b0100_0000,
    S_HOLD     = 8'b1000_0000
  } state_t;

endpackage : fuse_prog_pkg

// [src/fuse_prog_ctrl.sv]
// Programmer that drives a fuse-trimmed two-wire switch through its supply pin
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Blow each set bit, supply cycled between
// R2: Bit blow order free; lowest first here
// R3: Blown fuses stay set forever
// R4: More bits blowable until locked; OR result
// R5: Lock: key 7, blow key, four pulses, blow
// R6: Wait post-blow delay before removing supply
// R7: Lock only after all else programmed, verified
// R8: Fuse check key 7, try mode only
// R9: Fuse check allowed before and after lock
// R10: High threshold tests blown, low tests intact
// R11: Marginal fuse raises supply current 250 uA
// R12: Up-counting pulse raises operate point one step
// R13: Down-counting applies inverted code to field
// R14: Hysteresis fixed, not programmable
// R15: Find operate point in try, then blow
// R16: Blow key: nine mid, one high pulse
// R17: Blow address one-hot, n pulses bit n-1
// R18: Check code 7 low, 15 high threshold
// R19: Locked part refuses all but fuse check
// R20: Device counts falling pulse edges for address
module fuse_prog_ctrl #(
  parameter int PULSE_TICKS = fuse_prog_pkg::PULSE_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int GAP_TICKS   = fuse_prog_pkg::GAP_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int PWRUP_TICKS = fuse_prog_pkg::POWER_UP_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int BLOW_TICKS  = fuse_prog_pkg::BLOW_DURATION_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int POST_TICKS  = fuse_prog_pkg::POST_BLOW_DELAY_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int OFF_TICKS   = fuse_prog_pkg::POWER_OFF_US * 1000 / fuse_prog_pkg::TICK_NS,
  parameter int SETTLE_TICKS = fuse_prog_pkg::CHECK_SETTLE_US * 1000 / fuse_prog_pkg::TICK_NS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Supply pin driver and current sense
  output logic [1:0]       supply_level,
  input  wire logic        current_step
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fuse_prog_pkg::state_t state;
    logic [2:0]            stage;
    logic [6:0]            left;
    logic [fuse_prog_pkg::TIMER_W-1:0] timer;
    logic [5:0]            tick_div;
    logic [2:0]            op;
    logic [3:0]            key;
    logic [5:0]            code;
    logic [5:0]            bits_todo;
    logic [2:0]            cur_bit;
    logic                  check_high;
    logic                  arm_lock;
    logic                  done;
    logic                  error;
    logic                  marginal;
    logic                  locked;
    logic [5:0]            blown;
    logic [1:0]            level;
    logic                  sense_meta;
    logic                  sense;
    logic [31:0]           rdata;
    logic                  slverr;
  } regs_t;

  regs_t r;
  regs_t next_r;

  function automatic logic [2:0] lowest_bit(input logic [5:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = fuse_prog_pkg::FIELD_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_bit

  function automatic logic [15:0] ticks(input int n);
    return 16'(n);
  endfunction : ticks

  logic        tick;
  logic        expired;
  logic        busy;
  logic        setup;
  logic        blow_mode;
  logic [31:0] status;
  logic [3:0]  key_sel;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r    = r;
    tick      = (r.tick_div == 6'(fuse_prog_pkg::TICK_CYCLES - 1));
    expired   = (r.timer == 16'h0000);
    busy      = (r.state != fuse_prog_pkg::S_IDLE) && (r.state != fuse_prog_pkg::S_HOLD);
    setup     = psel && !penable;
    blow_mode = (r.op == fuse_prog_pkg::OP_BLOW) || (r.op == fuse_prog_pkg::OP_LOCK);
    key_sel   = (r.op == fuse_prog_pkg::OP_LOCK || r.op == fuse_prog_pkg::OP_CHECK) ?
                fuse_prog_pkg::KEY_LOCK_CHECK : r.key; // R5 R8
    status    = 32'h0000_0000;
    status[fuse_prog_pkg::ST_BUSY_BIT]   = busy;
    status[fuse_prog_pkg::ST_DONE_BIT]   = r.done;
    status[fuse_prog_pkg::ST_ERROR_BIT]  = r.error;
    status[fuse_prog_pkg::ST_MARGIN_BIT] = r.marginal;
    status[fuse_prog_pkg::ST_LOCKED_BIT] = r.locked;
    status[fuse_prog_pkg::ST_HOLD_BIT]   = (r.state == fuse_prog_pkg::S_HOLD);
    status[fuse_prog_pkg::ST_BLOWN_LSB +: 6] = r.blown;

    // Current-sense pin synchroniser
    next_r.sense_meta = current_step;
    next_r.sense      = r.sense_meta;

    // Tick divider and tick timer
    next_r.tick_div = tick ? 6'h00 : 6'(r.tick_div + 6'h01);
    if (tick && !expired) begin
      next_r.timer = 16'(r.timer - 16'h0001);
    end

    unique case (r.state)
      fuse_prog_pkg::S_IDLE: begin
        next_r.level = fuse_prog_pkg::LVL_OFF;
      end
      fuse_prog_pkg::S_POWER_UP: begin
        next_r.level = fuse_prog_pkg::LVL_NOM;
        if (expired) begin
          next_r.state   = fuse_prog_pkg::S_GAP;
          next_r.stage   = fuse_prog_pkg::STG_KEY_MID;
          next_r.left    = {3'h0, key_sel};
          next_r.cur_bit = lowest_bit(r.bits_todo); // R2
        end
      end
      fuse_prog_pkg::S_PULSE: begin
        if (expired) begin
          next_r.level    = fuse_prog_pkg::LVL_NOM;
          next_r.state    = fuse_prog_pkg::S_GAP;
          next_r.timer    = ticks(GAP_TICKS);
          next_r.tick_div = 6'h00;
        end
      end
      fuse_prog_pkg::S_GAP: begin
        if (expired) begin
          unique case (r.stage)
            fuse_prog_pkg::STG_KEY_MID, fuse_prog_pkg::STG_MODE_MID: begin
              next_r.state    = fuse_prog_pkg::S_PULSE;
              next_r.timer    = ticks(PULSE_TICKS);
              next_r.tick_div = 6'h00;
              if (r.left != 7'h00) begin
                next_r.level = fuse_prog_pkg::LVL_MID;
                next_r.left  = 7'(r.left - 7'h01);
              end else begin
                next_r.level = fuse_prog_pkg::LVL_HIGH;
                next_r.stage = 3'(r.stage + 3'h1); // R16
              end
            end
            fuse_prog_pkg::STG_KEY_HIGH: begin
              if (blow_mode) begin
                next_r.stage = fuse_prog_pkg::STG_MODE_MID;
                next_r.left  = fuse_prog_pkg::BLOW_MODE_KEY; // R16
              end else begin
                next_r.stage = fuse_prog_pkg::STG_ADDR;
                if (r.op == fuse_prog_pkg::OP_CHECK) begin
                  next_r.left = r.check_high ? fuse_prog_pkg::CHECK_CODE_HIGH
                                             : fuse_prog_pkg::CHECK_CODE_LOW; // R18 R10
                end else begin
                  next_r.left = {1'b0, r.code}; // R12 R13 R15
                end
              end
            end
            fuse_prog_pkg::STG_MODE_HIGH: begin
              next_r.stage = fuse_prog_pkg::STG_ADDR;
              next_r.left  = 7'({4'h0, r.cur_bit} + 7'h01); // R17 R5
            end
            default: begin
              next_r.tick_div = 6'h00;
              if (r.left != 7'h00) begin
                next_r.state = fuse_prog_pkg::S_PULSE;
                next_r.level = fuse_prog_pkg::LVL_MID;
                next_r.left  = 7'(r.left - 7'h01);
                next_r.timer = ticks(PULSE_TICKS);
              end else if (blow_mode) begin
                next_r.state = fuse_prog_pkg::S_BLOW;
                next_r.level = fuse_prog_pkg::LVL_HIGH;
                next_r.timer = ticks(BLOW_TICKS);
              end else begin
                next_r.state = fuse_prog_pkg::S_HOLD; // R8
                next_r.timer = ticks(SETTLE_TICKS);
                next_r.done  = 1'b1;
              end
            end
          endcase
        end
      end
      fuse_prog_pkg::S_BLOW: begin
        if (expired) begin
          next_r.level     = fuse_prog_pkg::LVL_NOM;
          next_r.state     = fuse_prog_pkg::S_POST;
          next_r.timer     = ticks(POST_TICKS);
          next_r.tick_div  = 6'h00;
          next_r.blown     = r.blown | (6'h01 << r.cur_bit); // R3 R4
          next_r.bits_todo = r.bits_todo & ~(6'h01 << r.cur_bit);
          if (r.op == fuse_prog_pkg::OP_LOCK) begin
            next_r.locked = 1'b1;
          end
        end
      end
      fuse_prog_pkg::S_POST: begin
        if (expired) begin
          next_r.level    = fuse_prog_pkg::LVL_OFF; // R6
          next_r.state    = fuse_prog_pkg::S_OFF;
          next_r.timer    = ticks(OFF_TICKS);
          next_r.tick_div = 6'h00;
        end
      end
      fuse_prog_pkg::S_OFF: begin
        next_r.level = fuse_prog_pkg::LVL_OFF;
        if (expired) begin
          if (r.bits_todo != 6'h00 && r.op == fuse_prog_pkg::OP_BLOW) begin
            next_r.state    = fuse_prog_pkg::S_POWER_UP; // R1
            next_r.level    = fuse_prog_pkg::LVL_NOM;
            next_r.timer    = ticks(PWRUP_TICKS);
            next_r.tick_div = 6'h00;
          end else begin
            next_r.state = fuse_prog_pkg::S_IDLE;
            next_r.done  = 1'b1;
          end
        end
      end
      fuse_prog_pkg::S_HOLD: begin
        // Supply stays up so the output and current can be observed
        if (r.op == fuse_prog_pkg::OP_CHECK && expired) begin
          next_r.marginal = r.sense; // R11
        end
      end
      default: begin
        next_r.state = fuse_prog_pkg::S_IDLE;
        next_r.level = fuse_prog_pkg::LVL_OFF;
      end
    endcase

    // ----------------------------------------------------------------
    // APB slave: read data and error taken in the setup cycle
    // ----------------------------------------------------------------
    if (setup) begin
      next_r.slverr = 1'b0;
      next_r.rdata  = 32'h0000_0000;
      unique case (paddr)
        fuse_prog_pkg::ADDR_CTRL:   next_r.rdata = {26'h000_0000, r.check_high, r.arm_lock, 1'b0, r.op};
        fuse_prog_pkg::ADDR_KEY:    next_r.rdata = {28'h000_0000, r.key};
        fuse_prog_pkg::ADDR_CODE:   next_r.rdata = {26'h000_0000, r.code};
        fuse_prog_pkg::ADDR_STATUS: next_r.rdata = status;
        default:                    next_r.slverr = 1'b1;
      endcase
    end

    if (psel && penable && pwrite) begin
      if (paddr == fuse_prog_pkg::ADDR_KEY) begin
        next_r.key = pwdata[3:0];
      end
      if (paddr == fuse_prog_pkg::ADDR_CODE) begin
        next_r.code = pwdata[5:0];
      end
      if (paddr == fuse_prog_pkg::ADDR_CTRL) begin
        next_r.arm_lock   = pwdata[fuse_prog_pkg::CTRL_ARM_BIT];
        next_r.check_high = pwdata[fuse_prog_pkg::CTRL_HIGH_BIT];
        if (pwdata[fuse_prog_pkg::CTRL_START_BIT]) begin
          if (pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] == fuse_prog_pkg::OP_OFF) begin
            if (r.state == fuse_prog_pkg::S_HOLD) begin
              next_r.state    = fuse_prog_pkg::S_OFF;
              next_r.level    = fuse_prog_pkg::LVL_OFF;
              next_r.timer    = ticks(OFF_TICKS);
              next_r.tick_div = 6'h00;
              next_r.op       = fuse_prog_pkg::OP_OFF;
              next_r.done     = 1'b0;
            end
          end else if (r.state != fuse_prog_pkg::S_IDLE) begin
            next_r.error = 1'b1;
          end else if (r.locked && pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] != fuse_prog_pkg::OP_CHECK) begin
            next_r.error = 1'b1; // R19 R9
          end else if (pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] == fuse_prog_pkg::OP_LOCK &&
                       !pwdata[fuse_prog_pkg::CTRL_ARM_BIT]) begin
            next_r.error = 1'b1; // R7
          end else if (pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] == fuse_prog_pkg::OP_BLOW && r.code == 6'h00) begin
            next_r.error = 1'b1;
          end else if (pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] > fuse_prog_pkg::OP_OFF) begin
            next_r.error = 1'b1;
          end else begin
            next_r.op        = pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3];
            next_r.bits_todo = (pwdata[fuse_prog_pkg::CTRL_OP_LSB +: 3] == fuse_prog_pkg::OP_LOCK) ?
                               fuse_prog_pkg::LOCK_BIT_MASK : r.code; // R1 R5
            next_r.state     = fuse_prog_pkg::S_POWER_UP;
            next_r.level     = fuse_prog_pkg::LVL_NOM;
            next_r.timer     = ticks(PWRUP_TICKS);
            next_r.tick_div  = 6'h00;
            next_r.done      = 1'b0;
            next_r.error     = 1'b0;
            next_r.marginal  = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      r       <= '0;
      r.state <= fuse_prog_pkg::S_IDLE;
      r.level <= fuse_prog_pkg::LVL_OFF;
      r.key   <= fuse_prog_pkg::KEY_TRIM_UP;
    end else begin
      r <= next_r;
    end
  end

  assign pready       = 1'b1;
  assign prdata       = r.rdata;
  assign pslverr      = r.slverr;
  assign supply_level = r.level;

endmodule : fuse_prog_ctrl

`default_nettype wire

// [sim/fuse_prog_chk.sv]
// Checker for the fuse trim programmer APB slave and supply-pin timing
`timescale 1ns/10ps
`default_nettype none
module fuse_prog_chk #(
  parameter int PULSE_TICKS = 20,
  parameter int BLOW_TICKS  = 200,
  parameter int POST_TICKS  = 100
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Supply pin
  input wire logic [1:0]  supply_level,
  input wire logic        current_step
);
  localparam int         PW   = PULSE_TICKS * fuse_prog_pkg::TICK_CYCLES;
  localparam int         BW   = BLOW_TICKS * fuse_prog_pkg::TICK_CYCLES;
  localparam int         QW   = POST_TICKS * fuse_prog_pkg::TICK_CYCLES;
  localparam logic [1:0] OFF  = fuse_prog_pkg::LVL_OFF;
  localparam logic [1:0] NOM  = fuse_prog_pkg::LVL_NOM;
  localparam logic [1:0] MID  = fuse_prog_pkg::LVL_MID;
  localparam logic [1:0] HIGH = fuse_prog_pkg::LVL_HIGH;
  int         mid_run;
  int         high_run;
  int         nom_run;
  logic [1:0] prev_level;
  logic       after_blow;
  logic       mapped;
  assign mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  // Run lengths of the mid, high and nominal supply levels
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mid_run    <= 0;
      high_run   <= 0;
      nom_run    <= 0;
      prev_level <= OFF;
      after_blow <= 1'b0;
    end else begin
      mid_run    <= (supply_level == MID) ? mid_run + 1 : 0;
      high_run   <= (supply_level == HIGH) ? high_run + 1 : 0;
      nom_run    <= (supply_level == NOM) ? nom_run + 1 : 0;
      prev_level <= supply_level;
      if (supply_level == OFF) after_blow <= 1'b0;
      else if (supply_level != HIGH && high_run >= BW - 1) after_blow <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_mid_end;
    mid_run != 0 && supply_level != MID;
  endsequence
  sequence s_high_end;
    high_run != 0 && supply_level != HIGH;
  endsequence
  property p_high_width;
    s_high_end |-> (high_run >= PW - 1 && high_run <= PW + 2) || (high_run >= BW - 1 && high_run <= BW + 2);
  endproperty
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (s_access |-> pslverr == !mapped) else $error("pslverr wrong");
  chk_read_hold: assert property (s_access |=> $stable(prdata)) else $error("prdata moved after access");
  chk_mid_width: assert property (s_mid_end |-> mid_run >= PW - 1 && mid_run <= PW + 2)
    else $error("mid pulse width wrong");
  chk_mid_to_nom: assert property (s_mid_end |-> supply_level == NOM)
    else $error("mid pulse not ended at nominal");
  chk_high_width: assert property (p_high_width) else $error("high pulse width wrong");
  chk_high_to_nom: assert property (s_high_end |-> supply_level == NOM)
    else $error("high pulse not ended at nominal");
  chk_post_delay: assert property (supply_level == OFF && nom_run != 0 && after_blow |-> nom_run >= QW - 1)
    else $error("supply removed too early");
  chk_off_to_nom: assert property (prev_level == OFF && supply_level != OFF |-> supply_level == NOM)
    else $error("power-up not at nominal");
endmodule : fuse_prog_chk
bind fuse_prog_ctrl fuse_prog_chk #(
  .PULSE_TICKS(PULSE_TICKS),
  .BLOW_TICKS (BLOW_TICKS),
  .POST_TICKS (POST_TICKS)
) u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .supply_level(supply_level), .current_step(current_step)
);
`default_nettype wire

// [sim/fuse_dev_model.sv]
// Behavioural model of the fuse-trimmed switch seen through its supply pin
`timescale 1ns/10ps
`default_nettype none
module fuse_dev_model (
  // Supply pin and current sense
  input  wire logic [1:0] supply_level,
  output logic            current_step,
  // Fuse faults set by the bench
  input  wire logic       weak_blown,
  input  wire logic       weak_intact
);
  logic [1:0] prev_level = 2'h0;
  logic [6:0] key        = 7'h00;
  logic [6:0] cnt        = 7'h00;
  logic [1:0] stage      = 2'h0;
  logic       blow_mode  = 1'b0;
  logic [5:0] trim_fuse  = 6'h00;
  logic [5:0] lock_fuse  = 6'h00;
  logic [5:0] try_val    = 6'h00;
  logic       locked;
  localparam int HYST_STEPS = 4;
  initial current_step = 1'b0;
  assign locked = lock_fuse[3];
  always @(supply_level) begin
    if (supply_level == fuse_prog_pkg::LVL_OFF) begin
      // Power loss drops key, count, mode and current step; try_val and fuses stay
      stage = 2'h0;
      cnt = 7'h00;
      key = 7'h00;
      blow_mode = 1'b0;
      current_step = 1'b0;
    end else if (prev_level == fuse_prog_pkg::LVL_MID && supply_level == fuse_prog_pkg::LVL_NOM) begin
      cnt = cnt + 7'h01;
      if (stage == 2'h1 && !blow_mode && !locked && key <= 7'h01)
        try_val = (key == 7'h01) ? ~cnt[5:0] : cnt[5:0];
      if (stage == 2'h1 && !blow_mode && key == 7'h07)
        current_step = (cnt == 7'h0F && weak_blown) || (cnt == 7'h07 && weak_intact);
    end else if (prev_level == fuse_prog_pkg::LVL_HIGH && supply_level == fuse_prog_pkg::LVL_NOM) begin
      if (stage == 2'h0) begin
        key = cnt;
        cnt = 7'h00;
        stage = 2'h1;
      end else if (stage == 2'h1 && cnt == 7'h09) begin
        blow_mode = 1'b1;
        cnt = 7'h00;
        stage = 2'h2;
      end else if (stage == 2'h2) begin
        if (!locked && cnt >= 7'h01 && cnt <= 7'h06) begin
          if (key == 7'h00) trim_fuse[cnt - 7'h01] = 1'b1;
          else if (key == 7'h07) lock_fuse[cnt - 7'h01] = 1'b1;
        end
        stage = 2'h3;
      end
    end
    prev_level = supply_level;
  end
endmodule : fuse_dev_model
`default_nettype wire

// [sim/test_fuse_trim_lock_and_check.sv]
// Self-checking bench for the fuse trim programmer
`timescale 1ns/10ps
`default_nettype none
module test_fuse_trim_lock_and_check;
  logic        core_clk    = 1'b0;
  logic        rstn        = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic        weak_blown  = 1'b0;
  logic        weak_intact = 1'b0;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        current_step;
  wire logic [31:0] prdata;
  wire logic [1:0]  supply_level;
  int          n_fail      = 0;
  int          check_count = 0;
  logic [31:0] rd;
  logic [31:0] st;
  logic        err;
  localparam int SIM_TICKS = 2;
  always #10 core_clk = ~core_clk;
  fuse_prog_ctrl #(.PULSE_TICKS(SIM_TICKS), .GAP_TICKS(SIM_TICKS), .PWRUP_TICKS(SIM_TICKS), .BLOW_TICKS(4),
    .POST_TICKS(3), .OFF_TICKS(SIM_TICKS), .SETTLE_TICKS(SIM_TICKS)) dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_level(supply_level), .current_step(current_step));
  fuse_dev_model u_dev (.supply_level(supply_level), .current_step(current_step),
    .weak_blown(weak_blown), .weak_intact(weak_intact));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setup(input logic [31:0] k, input logic [31:0] c);
    apb(1'b1, fuse_prog_pkg::ADDR_KEY, k);
    apb(1'b1, fuse_prog_pkg::ADDR_CODE, c);
  endtask : setup
  // Start an operation and poll until it is no longer busy
  task automatic run(input logic [2:0] op, input logic arm, input logic hi);
    apb(1'b1, fuse_prog_pkg::ADDR_CTRL, {26'h000_0000, hi, arm, op, 1'b1});
    st = 32'h0000_0001;
    for (int i = 0; i < 20000 && st[0] !== 1'b0; i++) begin
      apb(1'b0, fuse_prog_pkg::ADDR_STATUS, 32'h0000_0000);
      st = rd;
    end
    if (op == fuse_prog_pkg::OP_CHECK) begin
      repeat (3 * fuse_prog_pkg::TICK_CYCLES) @(posedge core_clk);
      apb(1'b0, fuse_prog_pkg::ADDR_STATUS, 32'h0000_0000);
      st = rd;
    end
  endtask : run
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, fuse_prog_pkg::ADDR_STATUS, 32'h0000_0000);
    check("status reset", rd, 32'h0000_0000);
    apb(1'b0, fuse_prog_pkg::ADDR_CTRL, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    check("unmapped", 32'(err), 32'h0000_0001);
    setup(32'h0000_0000, 32'h0000_0005);
    run(fuse_prog_pkg::OP_TRY, 1'b0, 1'b0);
    check("try up", 32'(u_dev.try_val), 32'h0000_0005);
    check("try status", 32'(st[5:0]), 32'h0000_0022);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    check("supply off", 32'(supply_level), 32'h0000_0000);
    setup(32'h0000_0001, 32'h0000_0001);
    run(fuse_prog_pkg::OP_TRY, 1'b0, 1'b0);
    check("try down", 32'(u_dev.try_val), 32'h0000_003E);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    setup(32'h0000_0000, 32'h0000_0005);
    run(fuse_prog_pkg::OP_BLOW, 1'b0, 1'b0);
    check("blow five", 32'(u_dev.trim_fuse), 32'h0000_0005);
    check("blow ok", 32'(st[2]), 32'h0000_0000);
    setup(32'h0000_0000, 32'h0000_0002);
    run(fuse_prog_pkg::OP_BLOW, 1'b0, 1'b0);
    check("blow more", 32'(u_dev.trim_fuse), 32'h0000_0007);
    setup(32'h0000_0000, 32'h0000_0000);
    run(fuse_prog_pkg::OP_BLOW, 1'b0, 1'b0);
    check("blow empty", 32'(st[2]), 32'h0000_0001);
    run(fuse_prog_pkg::OP_CHECK, 1'b0, 1'b0);
    check("check low", 32'(st[3]), 32'h0000_0000);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    weak_intact <= 1'b1;
    run(fuse_prog_pkg::OP_CHECK, 1'b0, 1'b0);
    check("check low weak", 32'(st[3]), 32'h0000_0001);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    weak_blown <= 1'b1;
    run(fuse_prog_pkg::OP_CHECK, 1'b0, 1'b1);
    check("check high", 32'(st[3]), 32'h0000_0001);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    run(fuse_prog_pkg::OP_LOCK, 1'b0, 1'b0);
    check("lock unarmed", {31'h0000_0000, st[2]} | {26'h000_0000, u_dev.lock_fuse}, 32'h0000_0001);
    run(fuse_prog_pkg::OP_LOCK, 1'b1, 1'b0);
    check("lock fuse", 32'(u_dev.lock_fuse), 32'h0000_0008);
    check("lock status", 32'(st[4]), 32'h0000_0001);
    setup(32'h0000_0000, 32'h0000_0010);
    run(fuse_prog_pkg::OP_BLOW, 1'b0, 1'b0);
    check("locked blow", {31'h0000_0000, st[2]} | {26'h000_0000, u_dev.trim_fuse}, 32'h0000_0007);
    run(fuse_prog_pkg::OP_TRY, 1'b0, 1'b0);
    check("locked try", 32'(st[2]), 32'h0000_0001);
    run(fuse_prog_pkg::OP_CHECK, 1'b0, 1'b1);
    check("check locked", 32'(st[3:2]), 32'h0000_0002);
    run(fuse_prog_pkg::OP_OFF, 1'b0, 1'b0);
    complete_run;
  end
endmodule : test_fuse_trim_lock_and_check
`default_nettype wire
